// file: mcpwm_timer.sv
// Eight-channel PWM timer with APB register access and pair concatenation
//
// Function
// - Per-channel bit selects left or center alignment
// - Unimplemented channel bits ignore writes, read zero
// - Four control bits join channel pairs
// - Even channel forms high byte of pair
// - Each channel has 8-bit counter, period, duty
// - Counter matching period sets output period
// - Counter matching duty flips output level
// - Starting output level selectable per channel
// - Enable bit turns channel output on immediately
// - Waveform waits for next source tick, except joined
// - First cycle after enable may be irregular
// - Enabled channel forces its pin to output
`timescale 1ns/10ps
`default_nettype none

module mcpwm_timer
    import mcpwm_pkg::*;
#(
    parameter int NUM_CH = 8                    // Implemented channels, even, 2..8
) (
    input wire logic clk_i,                     // 250 MHz bus clock
    input wire logic reset_n_i,                 // Asynchronous reset, active low
    input wire logic psel_i,                    // APB select
    input wire logic penable_i,                 // APB access phase
    input wire logic pwrite_i,                  // APB direction, high for write
    input wire logic [MCPWM_ADDR_W-1:0] paddr_i, // APB byte address
    input wire logic [MCPWM_DATA_W-1:0] pwdata_i, // APB write data
    output logic [MCPWM_DATA_W-1:0] prdata_o,   // APB read data
    output logic pready_o,                      // APB ready
    output logic pslverr_o,                     // APB error, unmapped address
    output logic [MCPWM_MAX_CH-1:0] pwm_out_o,  // Channel waveforms
    output logic [MCPWM_MAX_CH-1:0] pwm_oe_o    // Pin output enables
);

    // Refuse channel counts the pair logic cannot serve, at elaboration
    if (NUM_CH < 2 || NUM_CH > MCPWM_MAX_CH || (NUM_CH % 2) != 0) begin : g_bad_num_ch
        $error("NUM_CH must be even and between 2 and 8");
    end

    localparam int NUM_PAIRS = MCPWM_MAX_CH / 2;
    // Mask of implemented channels
    localparam logic [7:0] CH_MASK = 8'((9'h001 << NUM_CH) - 9'h001);
    // Mask of implemented join bits, placed at their field position
    // Built at full byte width so the shift to the field position keeps every bit
    localparam logic [7:0] CAT_MASK = 8'(((8'h01 << (NUM_CH / 2)) - 8'h01) << MCPWM_CTL_CAT_POS);

    // Software visible registers
    logic [7:0] enable_ff;                      // channel_output_enable bits
    logic [7:0] polarity_ff;                    // Starting level bits
    logic [7:0] clkdiv_ff;                      // Clock source divider
    logic [7:0] center_ff;                      // center_align_bits
    logic [7:0] control_ff;                     // pwm_control
    logic [7:0] period_ff [MCPWM_MAX_CH];       // Period per channel
    logic [7:0] duty_ff [MCPWM_MAX_CH];         // Duty per channel

    // Clock source prescaler
    logic [7:0] presc_ff;                       // Divider counter
    logic [7:0] nxt_presc;
    logic tick;                                 // One-cycle pulse, start of a source cycle

    // Channel state and outputs
    mcpwm_ch_state_t st_ff [MCPWM_MAX_CH];      // Counter state
    mcpwm_ch_state_t nxt_st [MCPWM_MAX_CH];
    logic [7:0] out_ff;                         // Registered waveforms
    logic [7:0] nxt_out;
    mcpwm_ch_cfg_t cfg [MCPWM_MAX_CH];          // Gathered configuration

    // APB response registers
    logic [MCPWM_DATA_W-1:0] prdata_ff;
    logic [MCPWM_DATA_W-1:0] nxt_prdata;
    logic pslverr_ff;
    logic nxt_pslverr;

    // Bus decode
    wire logic [MCPWM_IDX_W-1:0] idx = paddr_i[MCPWM_IDX_W+1:2];
    wire logic [2:0] sel_ch = idx[2:0] & MCPWM_ARRAY_SEL_W;
    wire logic setup = psel_i & ~penable_i;     // Read data is prepared here
    wire logic access = psel_i & penable_i;     // Writes land here
    wire logic high_zero = (paddr_i[MCPWM_ADDR_W-1:MCPWM_IDX_W+2] == '0) & (paddr_i[1:0] == 2'h0);
    wire logic hit_enable = high_zero & (idx == MCPWM_IDX_ENABLE);
    wire logic hit_polarity = high_zero & (idx == MCPWM_IDX_POLARITY);
    wire logic hit_clkdiv = high_zero & (idx == MCPWM_IDX_CLKDIV);
    wire logic hit_center = high_zero & (idx == MCPWM_IDX_CENTER);
    wire logic hit_control = high_zero & (idx == MCPWM_IDX_CONTROL);
    wire logic hit_count = high_zero & ((idx & ~6'h07) == MCPWM_IDX_COUNT_BASE);
    wire logic hit_period = high_zero & ((idx & ~6'h07) == MCPWM_IDX_PERIOD_BASE);
    wire logic hit_duty = high_zero & ((idx & ~6'h07) == MCPWM_IDX_DUTY_BASE);
    wire logic hit_any = hit_enable | hit_polarity | hit_clkdiv | hit_center | hit_control |
                         hit_count | hit_period | hit_duty;
    // Array slots of missing channels are unmapped
    wire logic ch_ok = CH_MASK[sel_ch];
    wire logic mapped = hit_any & (~(hit_count | hit_period | hit_duty) | ch_ok);
    wire logic wr = access & pwrite_i & mapped;
    wire logic [7:0] wbyte = pwdata_i[7:0];

    // Zero wait states: answer in the access cycle with data registered at setup
    assign pready_o = access;
    assign prdata_o = prdata_ff;
    assign pslverr_o = pslverr_ff & access;

    // Read multiplexer, missing channel bits always read zero
    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup) begin
            nxt_pslverr = ~mapped;
            nxt_prdata = '0;
            if (hit_enable) begin
                nxt_prdata[7:0] = enable_ff & CH_MASK;
            end else if (hit_polarity) begin
                nxt_prdata[7:0] = polarity_ff & CH_MASK;
            end else if (hit_clkdiv) begin
                nxt_prdata[7:0] = clkdiv_ff;
            end else if (hit_center) begin
                nxt_prdata[7:0] = center_ff & CH_MASK;
            end else if (hit_control) begin
                nxt_prdata[7:0] = control_ff & CAT_MASK;
            end else if (hit_count && ch_ok) begin
                nxt_prdata[7:0] = st_ff[sel_ch].cnt;
            end else if (hit_period && ch_ok) begin
                nxt_prdata[7:0] = period_ff[sel_ch];
            end else if (hit_duty && ch_ok) begin
                nxt_prdata[7:0] = duty_ff[sel_ch];
            end
        end
    end

    // Response registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Control registers; writes to missing channel bits are dropped
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enable_ff <= MCPWM_RST_ENABLE;
            polarity_ff <= MCPWM_RST_POLARITY;
            clkdiv_ff <= MCPWM_RST_CLKDIV;
            center_ff <= MCPWM_RST_CENTER;
            control_ff <= MCPWM_RST_CONTROL;
        end else if (wr) begin
            if (hit_enable) begin
                enable_ff <= wbyte & CH_MASK;
            end
            if (hit_polarity) begin
                polarity_ff <= wbyte & CH_MASK;
            end
            if (hit_clkdiv) begin
                clkdiv_ff <= wbyte;
            end
            if (hit_center) begin
                center_ff <= wbyte & CH_MASK;
            end
            if (hit_control) begin
                control_ff <= wbyte & CAT_MASK;
            end
        end
    end

    // Period and duty arrays, one word per channel
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < MCPWM_MAX_CH; i++) begin
                period_ff[i] <= MCPWM_RST_PERIOD;
                duty_ff[i] <= MCPWM_RST_DUTY;
            end
        end else if (wr) begin
            if (hit_period) begin
                period_ff[sel_ch] <= wbyte;
            end
            if (hit_duty) begin
                duty_ff[sel_ch] <= wbyte;
            end
        end
    end

    // Clock source: one tick every clkdiv+1 bus clocks, shared by all channels
    assign tick = (presc_ff >= clkdiv_ff);
    assign nxt_presc = tick ? 8'h00 : presc_ff + 8'h01;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            presc_ff <= 8'h00;
        end else begin
            presc_ff <= nxt_presc;
        end
    end

    // One counter step; returns {down, count}; 16 bits wide so pairs reuse it
    function automatic logic [16:0] step(input logic [15:0] c, input logic [15:0] p,
                                         input logic dn, input logic ctr);
        logic [16:0] r;
        r = {dn, c};
        if (!ctr) begin
            // Left aligned: up, back to zero after the period match
            r = (c == p) ? 17'h00000 : {1'b0, c + 16'h0001};
        end else if (!dn) begin
            // Center aligned rising half, turns at the period match
            if (c >= p) begin
                r = {1'b1, (c == 16'h0000) ? 16'h0000 : c - 16'h0001};
            end else begin
                r = {1'b0, c + 16'h0001};
            end
        end else begin
            // Center aligned falling half, turns at zero
            if (c == 16'h0000) begin
                r = {1'b0, (p == 16'h0000) ? 16'h0000 : 16'h0001};
            end else begin
                r = {1'b1, c - 16'h0001};
            end
        end
        return r;
    endfunction

    // Per-pair timers; the even channel is the high byte when the pair is joined
    for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
        localparam int E = 2 * g;
        localparam int O = 2 * g + 1;
        wire logic cat = control_ff[MCPWM_CTL_CAT_POS + g];
        // Joined counter, period and duty: even bytes on top
        wire logic [15:0] cnt16 = {st_ff[E].cnt, st_ff[O].cnt};
        wire logic [15:0] per16 = {cfg[E].per, cfg[O].per};
        wire logic [15:0] duty16 = {cfg[E].duty, cfg[O].duty};
        // Step results for the odd channel (8 or 16 bit) and the even one
        wire logic [16:0] s_lo = cat ? step(cnt16, per16, st_ff[O].down, cfg[O].center) :
                                       step({8'h00, st_ff[O].cnt}, {8'h00, cfg[O].per},
                                            st_ff[O].down, cfg[O].center);
        wire logic [16:0] s_hi = step({8'h00, st_ff[E].cnt}, {8'h00, cfg[E].per},
                                      st_ff[E].down, cfg[E].center);
        // Duty compare: below duty shows the starting level
        wire logic lo_lvl = cat ? (cnt16 < duty16) : (st_ff[O].cnt < cfg[O].duty);
        wire logic hi_lvl = st_ff[E].cnt < cfg[E].duty;

        // Gather configuration per channel
        for (genvar k = 0; k < 2; k++) begin : g_cfg
            assign cfg[E + k] = '{en: enable_ff[E + k], pol: polarity_ff[E + k],
                                  center: center_ff[E + k], per: period_ff[E + k],
                                  duty: duty_ff[E + k]};
        end

        // Next state of both channels of the pair
        always_comb begin
            nxt_st[O] = st_ff[O];
            nxt_st[E] = st_ff[E];
            if (!cfg[O].en) begin
                // Disabled channel parks at zero, counting up
                nxt_st[O] = '{run: 1'b0, down: 1'b0, cnt: 8'h00};
            end else if (!st_ff[O].run) begin
                // Joined pairs start at once, single ones at the next tick
                nxt_st[O].run = tick | cat;
            end else if (tick) begin
                nxt_st[O].cnt = s_lo[7:0];
                nxt_st[O].down = s_lo[16];
            end
            if (cat) begin
                // Joined: even counter carries the high byte of the odd chain
                nxt_st[E].run = 1'b0;
                nxt_st[E].down = 1'b0;
                nxt_st[E].cnt = (cfg[O].en && st_ff[O].run && tick) ? s_lo[15:8] :
                                (cfg[O].en ? st_ff[E].cnt : 8'h00);
            end else if (!cfg[E].en) begin
                nxt_st[E] = '{run: 1'b0, down: 1'b0, cnt: 8'h00};
            end else if (!st_ff[E].run) begin
                nxt_st[E].run = tick;
            end else if (tick) begin
                nxt_st[E].cnt = s_hi[7:0];
                nxt_st[E].down = s_hi[16];
            end
        end

        // Output levels: start level below duty; idle channels rest at its inverse; the even channel of a joined pair stays low
        assign nxt_out[O] = st_ff[O].run ? (lo_lvl ~^ cfg[O].pol) : ~cfg[O].pol;
        assign nxt_out[E] = cat ? 1'b0 :
                            (st_ff[E].run ? (hi_lvl ~^ cfg[E].pol) : ~cfg[E].pol);
    end

    // Channel state registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < MCPWM_MAX_CH; i++) begin
                st_ff[i] <= '{run: 1'b0, down: 1'b0, cnt: 8'h00};
            end
        end else begin
            for (int i = 0; i < MCPWM_MAX_CH; i++) begin
                st_ff[i] <= nxt_st[i];
            end
        end
    end

    // Output registers; missing channels stay low
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_ff <= 8'h00;
        end else begin
            out_ff <= nxt_out & CH_MASK;
        end
    end

    assign pwm_out_o = out_ff;
    // Pin direction follows the enable bit with no wait for the clock source
    assign pwm_oe_o = enable_ff;

endmodule

`default_nettype wire

// file: mcpwm_pkg.sv
// Package with register map, field layout, reset values and types of the PWM timer
package mcpwm_pkg;

    // APB geometry
    localparam int MCPWM_ADDR_W = 12;               // Byte address width on the bus
    localparam int MCPWM_DATA_W = 32;               // APB data width
    localparam int MCPWM_IDX_W = 6;                 // Word index width (paddr[7:2])
    localparam int MCPWM_MAX_CH = 8;                // Channels the map has room for
    localparam int MCPWM_CH_W = 8;                  // Counter, period and duty width

    // Register indices, byte address is four times the index
    localparam logic [5:0] MCPWM_IDX_ENABLE = 6'h00; // Channel output enables
    localparam logic [5:0] MCPWM_IDX_POLARITY = 6'h01; // Starting level per channel
    localparam logic [5:0] MCPWM_IDX_CLKDIV = 6'h02; // Channel clock source divider
    localparam logic [5:0] MCPWM_IDX_CENTER = 6'h04; // pwm_center_align_select
    localparam logic [5:0] MCPWM_IDX_CONTROL = 6'h05; // pwm_control
    localparam logic [5:0] MCPWM_IDX_COUNT_BASE = 6'h08; // Counters, read only, 8 words
    localparam logic [5:0] MCPWM_IDX_PERIOD_BASE = 6'h10; // Period registers, 8 words
    localparam logic [5:0] MCPWM_IDX_DUTY_BASE = 6'h18; // Duty registers, 8 words
    localparam logic [2:0] MCPWM_ARRAY_SEL_W = 3'h7; // Channel field mask inside an array

    // Field positions
    localparam int MCPWM_CTL_CAT_POS = 4;           // pwm_control bits 7..4 join pairs 67..01

    // Reset values
    localparam logic [7:0] MCPWM_RST_ENABLE = 8'h00;
    localparam logic [7:0] MCPWM_RST_POLARITY = 8'h00;
    localparam logic [7:0] MCPWM_RST_CLKDIV = 8'h00;
    localparam logic [7:0] MCPWM_RST_CENTER = 8'h00;
    localparam logic [7:0] MCPWM_RST_CONTROL = 8'h00;
    localparam logic [7:0] MCPWM_RST_PERIOD = 8'hFF;
    localparam logic [7:0] MCPWM_RST_DUTY = 8'h00;

    // One channel's configuration as the timer sees it
    typedef struct packed {
        logic en;             // channel_output_enable
        logic pol;            // Starting level of each period
        logic center;         // center_align_bits entry
        logic [7:0] per;      // Period value
        logic [7:0] duty;     // Duty value
    } mcpwm_ch_cfg_t;

    // Counter state of one channel
    typedef struct packed {
        logic run;            // Waveform running, set at a clock source tick, or at once for a joined pair
        logic down;           // Center mode counting direction
        logic [7:0] cnt;      // Channel counter
    } mcpwm_ch_state_t;

endpackage

// file: mcpwm_asserts.sv
// Port-level checker for the PWM timer
`timescale 1ns/10ps
`default_nettype none
module mcpwm_asserts
    import mcpwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [MCPWM_ADDR_W-1:0] paddr_i,
    input wire logic [MCPWM_DATA_W-1:0] pwdata_i,
    input wire logic [MCPWM_DATA_W-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [MCPWM_MAX_CH-1:0] pwm_out_o,
    input wire logic [MCPWM_MAX_CH-1:0] pwm_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic [5:0] idx = paddr_i[7:2]; // Word index of the request
    wire logic acc = psel_i && penable_i; // Access cycle
    wire logic setup = psel_i && !penable_i; // Setup cycle, read data loads here
    wire logic [7:0] wbyte = pwdata_i[7:0]; // Only the low byte is stored
    wire logic wr_en = acc && pwrite_i && (idx == MCPWM_IDX_ENABLE);
    // Upper address bits and byte lanes must be zero for a hit
    wire logic mapped = (paddr_i[11:8] == 4'h0) && (paddr_i[1:0] == 2'h0) &&
        (idx <= 6'h02 || idx == 6'h04 || idx == 6'h05 || (idx >= 6'h08 && idx <= 6'h1F));
    logic [7:0] pol_ff; // Starting levels as software last wrote them
    logic [7:0] cat_ff; // Join bits as software last wrote them
    logic [1:0] age_ff; // Cycles since reset, saturates so idle check skips start-up
    // Shadow copies of the registers the idle check depends on
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pol_ff <= 8'h00;
            cat_ff <= 8'h00;
            age_ff <= 2'h0;
        end else begin
            if (acc && pwrite_i && idx == MCPWM_IDX_POLARITY) pol_ff <= wbyte;
            if (acc && pwrite_i && idx == MCPWM_IDX_CONTROL) cat_ff <= wbyte & 8'hF0;
            if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
        end
    end
    oe_follows_en_a: assert property (wr_en |=> pwm_oe_o == $past(wbyte))
        else $error("pin enable does not follow enable write");
    oe_holds_a: assert property (!wr_en |=> $stable(pwm_oe_o))
        else $error("pin enable moved without enable write");
    ready_now_a: assert property (pready_o == acc)
        else $error("ready not tied to access phase");
    unmapped_err_a: assert property (acc |-> pslverr_o == !mapped)
        else $error("error response wrong for address");
    err_reads_zero_a: assert property (acc && !pwrite_i && !mapped |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    ctl_low_zero_a: assert property (acc && !pwrite_i && idx == MCPWM_IDX_CONTROL
        |-> prdata_o[3:0] == 4'h0)
        else $error("control low bits not zero");
    rdata_stands_a: assert property (!$past(setup) |-> $stable(prdata_o))
        else $error("read data moved outside setup");
    idle_level_a: assert property (age_ff == 2'h3 && cat_ff == 8'h00 && $past(cat_ff, 2) == 8'h00
        && pol_ff == $past(pol_ff, 2) |-> ((~pwm_oe_o & ~$past(pwm_oe_o) & ~$past(pwm_oe_o, 2))
        & (pwm_out_o ^ ~pol_ff)) == 8'h00)
        else $error("disabled channel not at idle level");
    cover property (wr_en && wbyte != 8'h00);
    cover property (acc && !mapped);
    cover property (acc && pwrite_i && idx == MCPWM_IDX_CENTER && wbyte != 8'h00);
endmodule
`default_nettype wire

// file: test_multi_channel_pwm_timer.sv
// Self-checking bench for the eight-channel PWM timer
`timescale 1ns/10ps
`default_nettype none
module test_multi_channel_pwm_timer
    import mcpwm_pkg::*;
;
    logic clk_i = 1'b0; // 250 MHz bus clock
    logic reset_n_i = 1'b0; // Held low for 12 cycles
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [MCPWM_ADDR_W-1:0] paddr_i = '0;
    logic [MCPWM_DATA_W-1:0] pwdata_i = '0;
    logic [MCPWM_DATA_W-1:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [7:0] pwm_out_o;
    logic [7:0] pwm_oe_o;
    logic [31:0] rdv; // Last read data
    logic errv; // Last error response
    int err_count = 0;
    int n_checks = 0;
    logic [5:0] cfg_idx [5] = '{MCPWM_IDX_ENABLE, MCPWM_IDX_POLARITY, MCPWM_IDX_CLKDIV,
        MCPWM_IDX_CENTER, MCPWM_IDX_CONTROL};
    always #2 clk_i = ~clk_i;
    mcpwm_timer #(.NUM_CH(8)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o));
    // Compare and count; one bit wider than a bus word so the error flag travels along
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= {4'h0, idx, 2'h0};
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        // Only the watchdog ends a wait for a slave that never answers
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, {24'h0, d}, r, e);
    endtask
    // High when the pin is at the starting level
    function automatic logic act(input int ch, input logic p);
        return pwm_out_o[ch] ~^ p;
    endfunction
    // One full period: time at starting level, then time at the other level
    task automatic measure(input int ch, input logic p, output int hi, output int lo);
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        @(negedge clk_i);
        while (act(ch, p) !== 1'b0 && n < 3000) begin @(negedge clk_i); n++; end
        while (act(ch, p) !== 1'b1 && n < 3000) begin @(negedge clk_i); n++; end
        while (act(ch, p) === 1'b1 && n < 3000) begin @(negedge clk_i); hi++; n++; end
        while (act(ch, p) === 1'b0 && n < 3000) begin @(negedge clk_i); lo++; n++; end
    endtask
    // Center mode passes each count twice except the turning points
    function automatic int exp_hi(int duty, bit ctr, int div);
        return (ctr ? 2 * duty - 1 : duty) * (div + 1);
    endfunction
    function automatic int exp_len(int per, bit ctr, int div);
        return (ctr ? 2 * per : per + 1) * (div + 1);
    endfunction
    // Hang guard, far above the expected run
    initial begin
        #(4 * 60000);
        err_count++;
        give_verdict();
    end
    initial begin
        int ch, per, duty, div, hi, lo;
        bit p, c;
        logic [7:0] v;
        void'($urandom(84532));
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // Outputs leave their reset value only at the first edge after release
        repeat (2) @(negedge clk_i);
        check("idle out", pwm_out_o, 8'hFF);
        check("reset oe", pwm_oe_o, 8'h00);
        // Reset value, read back and join-bit masking of the control registers
        for (int i = 0; i < 5; i++) begin
            v = 8'($urandom_range(255));
            apb(1'b0, cfg_idx[i], 32'h0, rdv, errv);
            check("cfg reset", rdv, 32'h0);
            wr(cfg_idx[i], v);
            apb(1'b0, cfg_idx[i], 32'h0, rdv, errv);
            check("cfg rw", rdv, {24'h0, (i == 4) ? (v & 8'hF0) : v});
            wr(cfg_idx[i], 8'h00);
        end
        // Counter slot ignores writes; holes answer with an error
        wr(6'(MCPWM_IDX_COUNT_BASE + 3), 8'h55);
        apb(1'b0, 6'(MCPWM_IDX_COUNT_BASE + 3), 32'h0, rdv, errv);
        check("count ro", {errv, rdv}, 33'h0);
        apb(1'b1, 6'h03, 32'hA5, rdv, errv);
        apb(1'b0, 6'h03, 32'h0, rdv, errv);
        check("hole", {errv, rdv}, {1'b1, 32'h0});
        $display("register tests done");
        // Random waveforms, first two are corner cases
        for (int t = 0; t < 6; t++) begin
            ch = $urandom_range(7);
            per = $urandom_range(30, 2);
            duty = $urandom_range(per - 1, 1);
            p = $urandom_range(1);
            c = $urandom_range(1);
            div = $urandom_range(2);
            if (t == 0) begin per = 255; duty = 254; c = 0; end
            if (t == 1) begin per = 2; duty = 1; c = 1; end
            wr(MCPWM_IDX_CLKDIV, 8'(div));
            wr(6'(MCPWM_IDX_PERIOD_BASE + ch), 8'(per));
            wr(6'(MCPWM_IDX_DUTY_BASE + ch), 8'(duty));
            apb(1'b0, 6'(MCPWM_IDX_PERIOD_BASE + ch), 32'h0, rdv, errv);
            check("period rw", rdv, 32'(per));
            wr(MCPWM_IDX_POLARITY, 8'(p) << ch);
            wr(MCPWM_IDX_CENTER, 8'(c) << ch);
            wr(MCPWM_IDX_ENABLE, 8'h01 << ch);
            @(negedge clk_i);
            check("run oe", pwm_oe_o, 8'h01 << ch);
            measure(ch, p, hi, lo); // First period may be irregular, so skipped
            measure(ch, p, hi, lo);
            check("length", hi + lo, exp_len(per, c, div));
            check("start time", hi, exp_hi(duty, c, div));
            apb(1'b0, 6'(MCPWM_IDX_COUNT_BASE + ch), 32'h0, rdv, errv);
            check("count range", rdv <= per, 1'b1);
            wr(MCPWM_IDX_ENABLE, 8'h00);
            repeat (4) @(negedge clk_i);
            check("off level", pwm_out_o[ch], !p);
            $display("wave test %0d done", t);
        end
        // Joined pair 0/1: even channel holds the high bytes
        wr(MCPWM_IDX_CLKDIV, 8'h00);
        wr(MCPWM_IDX_CENTER, 8'h00);
        wr(MCPWM_IDX_CONTROL, 8'h10); // Both channels off while joining
        wr(MCPWM_IDX_PERIOD_BASE, 8'h01);
        wr(6'(MCPWM_IDX_PERIOD_BASE + 1), 8'h10);
        wr(MCPWM_IDX_DUTY_BASE, 8'h00);
        wr(6'(MCPWM_IDX_DUTY_BASE + 1), 8'h50);
        wr(MCPWM_IDX_POLARITY, 8'h02);
        wr(MCPWM_IDX_ENABLE, 8'h02);
        measure(1, 1'b1, hi, lo);
        measure(1, 1'b1, hi, lo);
        check("joined length", hi + lo, 273);
        check("joined start", hi, 80);
        check("even pin", pwm_out_o[0], 1'b0);
        wr(MCPWM_IDX_ENABLE, 8'h00);
        wr(MCPWM_IDX_CONTROL, 8'h00);
        $display("joined test done");
        give_verdict();
    end
endmodule
bind mcpwm_timer mcpwm_asserts u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o));
`default_nettype wire
